// file: hdl/qrsp_pkg.sv
// Package: shared constants and types for the separate-port burst SRAM link.
// Assumes both ends run on one 200 MHz system clock; link clocks are sampled.
package qrsp_pkg;
  localparam int DATA_W = 36;          // Wide variant data width
  localparam int ADDR_W = 20;          // Wide variant address bits
  localparam int LANE_W = 9;           // Bits per byte lane
  localparam int LANES = DATA_W / LANE_W;
  localparam int BURST_LEN = 4;        // Beats per read or write
  localparam int DIV_HALF = 4;         // System cycles per link clock half period
  localparam int MEM_DEPTH_LOG2 = 6;   // Log2 of simulation model array depth
  localparam logic [1:0] BEAT_RESET = 2'h0;
  typedef enum logic [1:0] {QRSP_IDLE, QRSP_BURST, QRSP_TAIL} qrsp_rd_state_type;
endpackage

// file: hdl/qrsp_if.sv
// Interface: pins between controller and memory device.
// Assumes the bench resolves the data-out tristate from q_oe.
`timescale 1ns/1ps
interface qrsp_if;
  import qrsp_pkg::*;
  logic k;                                   // Positive input clock (inverse is other phase)
  logic c;                                   // Output clock
  logic single_clk;                          // Single clock mode strap
  logic write_port_select_n;
  logic read_port_select_n;
  logic [LANES-1:0] byte_lane_write_mask_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] q;
  logic q_oe;                                // High while device drives q
  logic cq;                                  // Echo clock
  modport ctrl (output k, c, single_clk, write_port_select_n, read_port_select_n,
    byte_lane_write_mask_n, addr, d, input q, q_oe, cq);
  modport dev (input k, c, single_clk, write_port_select_n, read_port_select_n,
    byte_lane_write_mask_n, addr, d, output q, q_oe, cq);
endinterface

// file: hdl/qrsp_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/1ps
module qrsp_skid #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk_in,            // System clock
  input wire logic rst_n_in,              // Async reset, active low
  input wire logic in_valid_in,           // Source has word
  output logic in_ready_out,              // Room for a word
  input wire logic [WIDTH-1:0] in_data_in, // Word in
  output logic out_valid_out,             // Word available
  input wire logic out_ready_in,          // Sink takes word
  output logic [WIDTH-1:0] out_data_out   // Word out
);
  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid_in && (count != 2'h2);
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];
  // Pointers and fill level
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
  // Storage needs no reset; valid gates it
  always_ff @(posedge sys_clk_in) begin
    if (push) mem[wr_ptr] <= in_data_in;
  end
endmodule

// file: hdl/qrsp_dev.sv
// Memory device end: samples link pins, stores bursts, returns read bursts.
// Assumes link clocks are slow against sys_clk and sampled by two flip-flops.
// How it works
// [R1] Write data captured on both K phases
// [R2] Low write select at K rise starts write
// [R3] Deselected write port ignores data
// [R4] Masks sampled with their data beat
// [R5] Each mask governs one 9-bit lane
// [R6] Masked lane data is not stored
// [R7] Read address at K, write at K-bar
// [R8] Address width fixed per variant
// [R9] Address ignored when port deselected
// [R10] Read beats driven on C edges
// [R11] Single clock mode drives on K edges
// [R12] Deselected read port floats outputs
// [R13] Low read select at K rise starts read
// [R14] Finish burst, float after next C rise
// [R15] Every read returns four beats
// [R16] Controller supplies output clock pair
// [R17] Output clocks deskew board flight times
// [R18] Accesses begin on K rising edge
// [R19] Echo clock follows C, or K
// [R20] Write moves four beats, masks each
`timescale 1ns/1ps
module qrsp_dev
  import qrsp_pkg::*;
#(
  parameter int DEPTH_LOG2 = qrsp_pkg::MEM_DEPTH_LOG2
) (
  input wire logic sys_clk_in,   // System clock
  input wire logic rst_n_in,     // Async reset, active low
  qrsp_if.dev link,              // Pins towards controller
  output logic busy_out          // Read burst under way
);
  import qrsp_pkg::*;

  // Two-stage synchronisers on all link pins, caught as one word so
  // that clocks, selects, masks and data keep their mutual alignment.
  localparam int SW = 5 + LANES + ADDR_W + DATA_W;
  // Idle pin levels: clocks low, selects and masks high, buses zero.
  // Resetting to these keeps the edge detectors from seeing a false
  // clock edge in the first cycles after reset.
  localparam logic [SW-1:0] SYNC_IDLE = {3'h0, 2'h3, {LANES{1'b1}}, {(ADDR_W + DATA_W){1'b0}}};
  logic [SW-1:0] meta;
  logic [SW-1:0] sync;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= SYNC_IDLE;
      sync <= SYNC_IDLE;
    end else begin
      meta <= {link.k, link.c, link.single_clk, link.write_port_select_n,
        link.read_port_select_n, link.byte_lane_write_mask_n, link.addr, link.d};
      sync <= meta;
    end
  end
  // Field views of the synchronised word, in the order caught above
  wire s_k = sync[SW-1];
  wire s_c = sync[SW-2];
  wire s_single = sync[SW-3];
  wire s_wps_n = sync[SW-4];
  wire s_rps_n = sync[SW-5];
  wire [LANES-1:0] s_mask_n = sync[SW-6 -: LANES];
  wire [ADDR_W-1:0] s_addr = sync[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] s_d = sync[DATA_W-1:0];

  // Edge detection of both phases; the delayed copies reset to the idle
  // clock level, so no edge is reported before the link clock moves.
  logic k_d;
  logic c_d;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      k_d <= 1'b0;
      c_d <= 1'b0;
    end else begin
      k_d <= s_k;
      c_d <= s_c;
    end
  end
  wire k_rise = s_k && !k_d;
  wire kb_rise = !s_k && k_d;
  wire k_edge = k_rise || kb_rise;          // [R1]

  // Output clock is C pair, or K pair in single clock mode
  // The device paces the read beats with these edges alone
  wire oc_rise = s_single ? k_rise : (s_c && !c_d);   // [R11]
  wire oc_fall = s_single ? kb_rise : (!s_c && c_d);
  wire oc_edge = oc_rise || oc_fall;                  // [R10]

  // Storage lives per lane in the generate loop further down. Only the
  // low address bits are kept, so a small array stands in for the full
  // part; the higher address bits are still taken in and simply alias.
  // Keep test addresses inside the modelled depth.
  wire [DATA_W-1:0] rd_word;

  // Write side: the select at a K rise arms the port, the address
  // follows at the K-bar rise, and that same edge carries beat 0.
  logic wr_pend;
  logic wr_act;
  logic [1:0] wr_beat;
  logic [ADDR_W-1:0] wr_addr;
  wire wr_start = k_rise && !s_wps_n && !wr_act;     // [R2] [R18]
  wire wr_take_addr = kb_rise && wr_pend;            // [R7] [R9]
  wire wr_do = wr_act && k_edge;                     // [R3] data read only in burst
  wire [DEPTH_LOG2-1:0] wr_idx = DEPTH_LOG2'(wr_addr) + DEPTH_LOG2'(wr_beat);
  wire wr_lane_en = wr_do || wr_take_addr;
  wire [DEPTH_LOG2-1:0] wr_lane_idx = wr_take_addr ? DEPTH_LOG2'(s_addr) : wr_idx;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend <= 1'b0;
      wr_act <= 1'b0;
      wr_beat <= BEAT_RESET;
      wr_addr <= '0;
    end else begin
      if (wr_start) wr_pend <= 1'b1;
      if (wr_take_addr) begin
        wr_pend <= 1'b0;
        wr_act <= 1'b1;
        wr_addr <= s_addr;                            // [R8]
        // Beat 0 lands with the address, so the burst goes on at beat 1
        wr_beat <= 2'h1;
      end else if (wr_do) begin
        wr_beat <= wr_beat + 2'h1;                    // [R20]
        if (wr_beat == 2'(BURST_LEN-1)) wr_act <= 1'b0;
      end
    end
  end

  // Read side: the read address is taken at the K rise that carries
  // the select; beats leave on the output clock edges that follow.
  qrsp_rd_state_type rd_state;
  qrsp_rd_state_type next_rd_state;
  logic [1:0] rd_beat;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] q;
  logic q_oe;
  logic cq;
  wire rd_start = k_rise && !s_rps_n;                // [R13] [R18]
  wire [DEPTH_LOG2-1:0] rd_idx = DEPTH_LOG2'(rd_addr) + DEPTH_LOG2'(rd_beat);
  wire last_beat = (rd_beat == 2'(BURST_LEN-1));     // [R15]
  wire rd_accept = rd_start && (rd_state == QRSP_IDLE || (rd_state == QRSP_TAIL && oc_rise));

  // Lane-wise storage; each lane owns its array so that lanes written by
  // separate processes never share a variable. Unwritten lanes keep old
  // contents. The arrays need no reset: a read of a word never written
  // returns unknowns, which the controller side must not rely on.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [2**DEPTH_LOG2];
      always_ff @(posedge sys_clk_in) begin
        if (wr_lane_en && !s_mask_n[g]) begin          // [R4] [R5] [R6]
          lane_mem[wr_lane_idx] <= s_d[g*LANE_W +: LANE_W];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_idx];
    end
  endgenerate

  // Burst state: a select at the closing C rise of a tail starts the next
  // burst at once, so back-to-back reads lose no command; the outputs
  // still float for that half period, which marks the burst boundary.
  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      QRSP_IDLE: if (rd_start) next_rd_state = QRSP_BURST;
      QRSP_BURST: if (oc_edge && last_beat) next_rd_state = QRSP_TAIL;
      QRSP_TAIL: begin
        if (rd_accept) next_rd_state = QRSP_BURST;         // [R13]
        else if (oc_rise) next_rd_state = QRSP_IDLE;       // [R14]
      end
      default: next_rd_state = QRSP_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_state <= QRSP_IDLE;
      rd_beat <= BEAT_RESET;
      rd_addr <= '0;
      q <= '0;
      q_oe <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      if (rd_accept) begin
        rd_addr <= s_addr;                            // [R7] [R8]
        rd_beat <= BEAT_RESET;
      end
      if (rd_state == QRSP_BURST && oc_edge) begin
        q <= rd_word;                                 // [R10] [R11]
        q_oe <= 1'b1;
        rd_beat <= rd_beat + 2'h1;
      end
      if (rd_state == QRSP_TAIL && oc_rise) q_oe <= 1'b0;  // [R12] [R14]
    end
  end

  // Echo clock tracks the chosen output clock
  // It runs free, whether or not a read is under way, so the controller
  // can lock onto it before the first burst.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cq <= 1'b0;
    else cq <= s_single ? s_k : s_c;                  // [R19]
  end

  // Pins back to the controller; q keeps its last beat while q_oe is low
  assign link.q = q;
  assign link.q_oe = q_oe;
  assign link.cq = cq;
  assign busy_out = q_oe;
endmodule

// file: hdl/qrsp_ctrl.sv
// Controller end: makes K and C by division, issues write and read bursts.
// Assumes one request at a time; read beats leave through a two-entry buffer.
`timescale 1ns/1ps
module qrsp_ctrl
  import qrsp_pkg::*;
(
  input wire logic sys_clk_in,                    // System clock
  input wire logic rst_n_in,                      // Async reset, active low
  qrsp_if.ctrl link,                              // Pins towards memory
  input wire logic req_valid_in,                  // Request present
  input wire logic req_write_in,                  // 1 write, 0 read
  input wire logic [ADDR_W-1:0] req_addr_in,      // Burst start address
  input wire logic [4*DATA_W-1:0] req_wdata_in,   // Four beats, beat 0 low
  input wire logic [4*LANES-1:0] req_mask_n_in,   // Masks per beat, active low
  input wire logic single_clk_in,                 // Single clock mode
  output logic req_ready_out,                     // Request taken
  output logic rd_valid_out,                      // Read beat available
  input wire logic rd_ready_in,                   // User takes beat
  output logic [DATA_W-1:0] rd_data_out           // Read beat
);
  import qrsp_pkg::*;
  // Link clock divider: K toggles every DIV_HALF cycles, C is K [R16]
  logic [2:0] div;
  logic k;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div <= 3'h0;
      k <= 1'b0;
    end else if (div == 3'(DIV_HALF-1)) begin
      div <= 3'h0;
      k <= ~k;
    end else begin
      div <= div + 3'h1;
    end
  end
  wire tick = (div == 3'(DIV_HALF-1));
  wire k_rise_next = tick && !k;
  // Sample returned data and enable
  logic [DATA_W:0] q_meta;
  logic [DATA_W:0] q_sync;
  logic oe_d;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_meta <= '0;
      q_sync <= '0;
      oe_d <= 1'b0;
    end else begin
      q_meta <= {link.q_oe, link.q};
      q_sync <= q_meta;
      oe_d <= q_sync[DATA_W];
    end
  end
  // Beat arrives when sampled q changes under enable, echo clock unused; count per burst [R15] [R17]
  logic [DATA_W-1:0] q_prev;
  logic [2:0] rd_got;
  logic busy;
  logic is_wr;
  logic [2:0] beat;
  logic wps_n;
  logic rps_n;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0] mask_n;
  logic [4*DATA_W-1:0] wbuf;
  logic [4*LANES-1:0] mbuf;
  logic push;
  logic buf_ready;
  wire take = req_valid_in && !busy && k_rise_next && buf_ready;
  wire q_beat = q_sync[DATA_W] && (!oe_d || q_sync[DATA_W-1:0] != q_prev);
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      is_wr <= 1'b0;
      beat <= 3'h0;
      wps_n <= 1'b1;
      rps_n <= 1'b1;
      addr <= '0;
      waddr <= '0;
      d <= '0;
      mask_n <= '1;
      wbuf <= '0;
      mbuf <= '1;
      req_ready_out <= 1'b0;
      q_prev <= '0;
      rd_got <= 3'h0;
      push <= 1'b0;
    end else begin
      req_ready_out <= take;
      push <= 1'b0;
      q_prev <= q_sync[DATA_W-1:0];
      if (take) begin                                 // [R18] select set in the same cycle as K rise
        busy <= 1'b1;
        is_wr <= req_write_in;
        beat <= 3'h0;
        wps_n <= !req_write_in;                       // [R2]
        rps_n <= req_write_in;                        // [R13]
        addr <= req_addr_in;                          // [R7] read addr for K
        waddr <= req_addr_in;
        wbuf <= req_wdata_in;
        mbuf <= req_mask_n_in;
        rd_got <= 3'h0;
      end else if (busy && tick) begin
        wps_n <= 1'b1;
        rps_n <= 1'b1;
        if (is_wr) begin
          // Each phase carries one beat with its mask [R1] [R4] [R20]
          addr <= waddr;                              // [R7] write addr for K-bar
          if (beat < 3'(BURST_LEN)) begin
            d <= wbuf[DATA_W-1:0];
            mask_n <= mbuf[LANES-1:0];
            wbuf <= wbuf >> DATA_W;
            mbuf <= {{LANES{1'b1}}, mbuf[4*LANES-1:LANES]};
            beat <= beat + 3'h1;
          end else begin
            mask_n <= '1;
            busy <= 1'b0;
          end
        end
      end
      if (busy && !is_wr && q_beat) begin
        push <= 1'b1;
        rd_got <= rd_got + 3'h1;
        if (rd_got == 3'(BURST_LEN-1)) busy <= 1'b0;
      end
    end
  end
  qrsp_skid #(.WIDTH(DATA_W)) u_buf (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_ready_out(buf_ready),
    .in_data_in(q_prev),
    .out_valid_out(rd_valid_out),
    .out_ready_in(rd_ready_in),
    .out_data_out(rd_data_out)
  );
  assign link.k = k;
  assign link.c = k;
  assign link.single_clk = single_clk_in;
  assign link.write_port_select_n = wps_n;
  assign link.read_port_select_n = rps_n;
  assign link.byte_lane_write_mask_n = mask_n;
  assign link.addr = addr;
  assign link.d = d;
endmodule

// file: verif/qrsp_assertions.sv
// Checker: timing relations on the link pins.
// Assumes it is instantiated beside the interface joining both ends.
`timescale 1ns/1ps
module qrsp_assertions
  import qrsp_pkg::*;
(
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic k, // Input clock
  input wire logic c, // Output clock
  input wire logic cq, // Echo clock
  input wire logic single_clk, // Mode
  input wire logic write_port_select_n, // Write select
  input wire logic read_port_select_n, // Read select
  input wire logic [LANES-1:0] byte_lane_write_mask_n, // Masks
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic q_oe // Device drives q
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] rd_age;
  logic [7:0] wr_age;
  logic [7:0] oe_len;
  // Ages saturate so a long idle spell cannot wrap into the window
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_age <= 8'hff;
      wr_age <= 8'hff;
      oe_len <= 8'h00;
    end else begin
      rd_age <= !read_port_select_n ? 8'h00 : rd_age + 8'(rd_age != 8'hff);
      wr_age <= !write_port_select_n ? 8'h00 : wr_age + 8'(wr_age != 8'hff);
      oe_len <= !q_oe ? 8'h00 : oe_len + 8'(oe_len != 8'hff);
    end
  end
  a_wsel_half_period: assert property ($fell(write_port_select_n) |->
    (!write_port_select_n)[*4] ##[1:2] write_port_select_n) else $error("write select width");
  a_access_at_krise: assert property (($fell(write_port_select_n) ||
    $fell(read_port_select_n)) |-> ##[0:2] $rose(k)) else $error("access off k rise");
  a_wr_addr_hold: assert property ($fell(write_port_select_n) |->
    ##1 $stable(addr)[*5]) else $error("write address moved");
  a_read_needs_sel: assert property ($rose(q_oe) |-> rd_age < 8'd48)
    else $error("output on without read");
  a_burst_min_len: assert property ($fell(q_oe) |-> oe_len >= 8'd12)
    else $error("read burst short");
  a_burst_max_len: assert property (oe_len <= 8'd40)
    else $error("outputs not floated");
  a_mask_in_write: assert property ((byte_lane_write_mask_n != '1) |->
    wr_age < 8'd40) else $error("mask outside write");
  a_echo_follows: assert property ($rose(c) |-> ##[1:4] cq)
    else $error("echo clock missing");
  a_outclk_period: assert property ($rose(c) |-> ##[7:9] $rose(c))
    else $error("output clock stalled");
  c_write: cover property ($fell(write_port_select_n));
  c_read: cover property ($fell(read_port_select_n));
  c_single_burst: cover property ($fell(q_oe) && single_clk);
endmodule

// file: verif/testbench.sv
// Testbench: drives controller requests, checks read bursts against a model.
// Assumes controller and device face each other over one interface.
`timescale 1ns/1ps
module testbench;
  import qrsp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [4*DATA_W-1:0] req_wdata_in = '0;
  logic [4*LANES-1:0] req_mask_n_in = '1;
  logic single_clk_in = 1'b0;
  logic rd_ready_in = 1'b0;
  logic req_ready_out;
  logic rd_valid_out;
  logic [DATA_W-1:0] rd_data_out;
  logic busy_out;
  integer seed = 32'h44c8;
  int miscompares = 0;
  int num_checks = 0;
  logic [DATA_W-1:0] expect_q[$];
  logic [DATA_W-1:0] mem_model [0:3][0:3];
  logic [6:0] tag_count = 7'h00;
  qrsp_if qrsp_if_i ();
  qrsp_ctrl qrsp_ctrl_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(qrsp_if_i),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_mask_n_in(req_mask_n_in),
    .single_clk_in(single_clk_in), .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out));
  qrsp_dev qrsp_dev_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(qrsp_if_i),
    .busy_out(busy_out));
  qrsp_assertions qrsp_assertions_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .k(qrsp_if_i.k), .c(qrsp_if_i.c), .cq(qrsp_if_i.cq), .single_clk(qrsp_if_i.single_clk),
    .write_port_select_n(qrsp_if_i.write_port_select_n),
    .read_port_select_n(qrsp_if_i.read_port_select_n),
    .byte_lane_write_mask_n(qrsp_if_i.byte_lane_write_mask_n),
    .addr(qrsp_if_i.addr), .q_oe(qrsp_if_i.q_oe));
  always #2.5 sys_clk_in = ~sys_clk_in;
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the controller's taken pulse, bounded
  task automatic request(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [4*DATA_W-1:0] wd, input logic [4*LANES-1:0] mk);
    int n;
    @(posedge sys_clk_in);
    #1;
    req_valid_in = 1'b1;
    req_write_in = wr;
    req_addr_in = a;
    req_wdata_in = wd;
    req_mask_n_in = mk;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 400);
    if (n >= 400) begin
      miscompares++;
      $display("CHECK FAILED at %0t: request not taken", $time);
    end
    #1;
    req_valid_in = 1'b0;
  endtask
  // Lane 0 is always written with a unique tag so adjacent beats differ
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [4*LANES-1:0] mk);
    logic [4*DATA_W-1:0] wd;
    logic [31:0] r;
    mk = mk & 16'heeee;
    for (int b = 0; b < 4; b++) begin
      r = $random(seed);
      wd[b*DATA_W +: DATA_W] = {r[26:0], tag_count, 2'(b)};
      for (int l = 0; l < LANES; l++) begin
        if (!mk[b*LANES+l]) mem_model[a[3:2]][b][l*LANE_W +: LANE_W] =
          wd[b*DATA_W+l*LANE_W +: LANE_W];
      end
    end
    tag_count++;
    request(1'b1, a, wd, mk);
  endtask
  task automatic read_burst(input logic [ADDR_W-1:0] a);
    for (int b = 0; b < 4; b++) expect_q.push_back(mem_model[a[3:2]][b]);
    request(1'b0, a, '0, '1);
  endtask
  task automatic wait_drain();
    int n;
    n = 0;
    while (expect_q.size() != 0 && n < 2000) begin
      @(posedge sys_clk_in);
      n++;
    end
    repeat (40) @(posedge sys_clk_in);
    #1;
  endtask
  // Receiver stalls at random to exercise the two-entry buffer
  always @(posedge sys_clk_in) begin
    #1;
    rd_ready_in = ($random(seed) % 4) != 0;
  end
  always @(posedge sys_clk_in) begin
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1) begin
      if (expect_q.size() == 0) begin
        miscompares++;
        $display("CHECK FAILED at %0t: unrequested read beat", $time);
      end else begin
        check(rd_data_out, expect_q.pop_front());
      end
    end
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    for (int m = 0; m < 2; m++) begin
      single_clk_in = 1'(m);
      for (int i = 0; i < 4; i++) write_burst(20'(i*4), 16'h0000);
      read_burst(20'h0);
      read_burst(20'h4);
      write_burst(20'h4, 16'($random(seed)));
      write_burst(20'h8, 16'hffff);
      for (int i = 3; i >= 0; i--) read_burst(20'(i*4));
      wait_drain();
      check({35'h0, qrsp_if_i.q_oe}, '0);
      check({35'h0, busy_out}, '0);
    end
    check(DATA_W'(expect_q.size()), '0);
    complete_run();
  end
endmodule
